// file: core/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
    localparam int ADDR_W        = 16;
    localparam int PAGE_BYTES    = 512;
    localparam int ROW_BYTES     = 64;
    localparam int PAGE_ROWS     = 8;
    localparam int PAGE_LSB      = 9;
    localparam int PAGE_SEL_W    = 7;
    localparam int OPTION_BYTES  = 2;
    localparam int TOP_MIN_BYTES = 1024;
    localparam int TOP_MAX_BYTES = 4096;
    localparam int FLASH_BYTES   = 65536;

    localparam logic [7:0] CMD_UNLOCK1    = 8'h73;
    localparam logic [7:0] CMD_UNLOCK2    = 8'h8C;
    localparam logic [7:0] CMD_PAGE_ERASE = 8'h95;
    localparam logic [7:0] CMD_MASS_ERASE = 8'h63;
    localparam logic [7:0] ERASED_BYTE    = 8'hFF;

    // register indices; byte address is four times the index
    localparam logic [11:0] IDX_CMD_STAT = 12'hFF8;
    localparam logic [11:0] IDX_PAGE_SEL = 12'hFF9;
    localparam logic [11:0] IDX_KHZ_HIGH = 12'hFFA;
    localparam logic [11:0] IDX_KHZ_LOW  = 12'hFFB;
    localparam int          IDX_LSB      = 2;

    localparam logic [5:0] STAT_LOCKED   = 6'h00;
    localparam logic [5:0] STAT_FIRST    = 6'h01;
    localparam logic [5:0] STAT_UNLOCKED = 6'h02;
    localparam logic [5:0] STAT_PROG     = 6'h08;
    localparam logic [5:0] STAT_PERASE   = 6'h10;
    localparam logic [5:0] STAT_MERASE   = 6'h20;

    // timer counts khz*us; one clock cycle adds this much
    localparam logic [39:0] TICK_STEP    = 40'h3E8;
    localparam int          PROG_US      = 40;
    localparam int          PERASE_US    = 10000;
    localparam int          MERASE_US    = 200000;

    typedef enum logic [2:0] {
        ST_LOCKED,
        ST_FIRST,
        ST_UNLOCKED,
        ST_PROG,
        ST_PERASE,
        ST_MERASE
    } ctrl_state_t;
endpackage

// file: core/flash_program_erase_controller.sv
`timescale 1ns/1ns
module flash_program_erase_controller
    import flash_ctrl_pkg::*;
#(
    parameter int TOP_SECTOR_BYTES = 1024,
    parameter int PROG_TIME_US     = PROG_US,
    parameter int PERASE_TIME_US   = PERASE_US,
    parameter int MERASE_TIME_US   = MERASE_US
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    input  wire logic              dbg_access,
    input  wire logic              pm_wr_valid,
    input  wire logic [ADDR_W-1:0] pm_wr_addr,
    input  wire logic [7:0]        pm_wr_data,
    input  wire logic              global_write_enable,
    input  wire logic              top_sector_write_enable,
    input  wire logic              code_read_protect,
    input  wire logic [7:0]        arr_rdata,
    output logic      [ADDR_W-1:0] arr_addr,
    output logic      [7:0]        arr_wdata,
    output logic                   arr_prog,
    output logic                   arr_page_erase,
    output logic                   arr_mass_erase,
    output logic                   cpu_hold,
    output logic                   dbg_read_denied
);
    localparam logic [ADDR_W-1:0] TOP_BASE =
        ADDR_W'(FLASH_BYTES - TOP_SECTOR_BYTES);

    if (TOP_SECTOR_BYTES < TOP_MIN_BYTES || TOP_SECTOR_BYTES > TOP_MAX_BYTES
        || TOP_SECTOR_BYTES % PAGE_BYTES != 0) begin : g_top_check
        $error("top sector size not supported");
    end
    if (PAGE_BYTES != PAGE_ROWS * ROW_BYTES
        || PAGE_BYTES != (1 << PAGE_LSB)) begin : g_page_check
        $error("page geometry inconsistent");
    end

    typedef struct packed {
        ctrl_state_t             st;
        logic [PAGE_SEL_W-1:0]   page;
        logic [7:0]              khz_hi;
        logic [7:0]              khz_lo;
        logic                    wr_pend;
        logic [11:0]             wr_idx;
        logic                    wr_dbg;
        logic [31:0]             rdata;
        logic                    ready;
        logic [ADDR_W-1:0]       a_addr;
        logic [7:0]              a_wdata;
        logic                    a_prog;
        logic                    a_perase;
        logic                    a_merase;
        logic                    rd_phase;
        logic [39:0]             acc;
        logic [39:0]             target;
        logic                    hold;
        logic                    rd_deny;
    } state_t;

    state_t s_q;
    state_t s_d;

    // option bits decide whether an address may be changed
    function automatic logic addr_writable(input logic [ADDR_W-1:0] a,
                                           input logic gwe,
                                           input logic tse);
        addr_writable = gwe || (tse && a >= TOP_BASE);
    endfunction

    function automatic logic [5:0] status_of(input ctrl_state_t st);
        case (st)
            ST_LOCKED:   status_of = STAT_LOCKED;
            ST_FIRST:    status_of = STAT_FIRST;
            ST_UNLOCKED: status_of = STAT_UNLOCKED;
            ST_PROG:     status_of = STAT_PROG;
            ST_PERASE:   status_of = STAT_PERASE;
            ST_MERASE:   status_of = STAT_MERASE;
            default:     status_of = STAT_LOCKED;
        endcase
    endfunction

    function automatic logic [39:0] op_target(input logic [15:0] khz,
                                              input int us);
        op_target = 40'(khz) * 40'(us);
    endfunction

    function automatic logic [31:0] reg_read(input logic [11:0] idx,
                                             input state_t v);
        case (idx)
            IDX_CMD_STAT: reg_read = {26'h0, status_of(v.st)};
            IDX_PAGE_SEL: reg_read = {25'h0, v.page};
            IDX_KHZ_HIGH: reg_read = {24'h0, v.khz_hi};
            IDX_KHZ_LOW:  reg_read = {24'h0, v.khz_lo};
            default:      reg_read = 32'h0;
        endcase
    endfunction

    logic              cmd_wr;
    logic [7:0]        wbyte;
    logic [15:0]       khz;
    logic              timer_done;
    logic [ADDR_W-1:0] page_base;

    always_comb begin
        s_d        = s_q;
        wbyte      = hwdata[7:0];
        khz        = {s_q.khz_hi, s_q.khz_lo};
        cmd_wr     = s_q.wr_pend && s_q.wr_idx == IDX_CMD_STAT;
        timer_done = (s_q.acc + TICK_STEP) >= s_q.target;
        page_base  = {s_q.page, {PAGE_LSB{1'b0}}};
        s_d.ready   = 1'b1;
        s_d.wr_pend = 1'b0;
        s_d.rd_deny = code_read_protect;
        if (s_q.wr_pend && s_q.wr_idx == IDX_PAGE_SEL) begin
            s_d.page = wbyte[PAGE_SEL_W-1:0];
        end
        if (s_q.wr_pend && s_q.wr_idx == IDX_KHZ_HIGH) begin
            s_d.khz_hi = wbyte;
        end
        if (s_q.wr_pend && s_q.wr_idx == IDX_KHZ_LOW) begin
            s_d.khz_lo = wbyte;
        end
        case (s_q.st)
            ST_LOCKED: begin
                // program-memory writes are dropped while locked
                if (cmd_wr && wbyte == CMD_UNLOCK1) begin
                    s_d.st = ST_FIRST;
                end
            end
            ST_FIRST: begin
                if (cmd_wr) begin
                    s_d.st = (wbyte == CMD_UNLOCK2) ? ST_UNLOCKED : ST_LOCKED;
                end
            end
            ST_UNLOCKED: begin
                if (cmd_wr) begin
                    s_d.st = ST_LOCKED;
                    s_d.acc = 40'h0;
                    if (wbyte == CMD_PAGE_ERASE
                        && addr_writable(page_base, global_write_enable,
                                         top_sector_write_enable)) begin
                        s_d.st       = ST_PERASE;
                        s_d.a_addr   = page_base;
                        s_d.a_perase = 1'b1;
                        s_d.hold     = 1'b1;
                        s_d.target   = op_target(khz, PERASE_TIME_US);
                    end
                    if (wbyte == CMD_MASS_ERASE
                        && (global_write_enable || s_q.wr_dbg)) begin
                        s_d.st       = ST_MERASE;
                        s_d.a_addr   = '0;
                        s_d.a_merase = 1'b1;
                        s_d.hold     = 1'b1;
                        s_d.target   = op_target(khz, MERASE_TIME_US);
                    end
                end else if (pm_wr_valid) begin
                    // option bytes at the bottom sit in the same array
                    if (addr_writable(pm_wr_addr, global_write_enable,
                                      top_sector_write_enable)) begin
                        s_d.st       = ST_PROG;
                        s_d.a_addr   = pm_wr_addr;
                        s_d.a_wdata  = pm_wr_data;
                        s_d.rd_phase = 1'b1;
                        s_d.hold     = 1'b1;
                        s_d.acc      = 40'h0;
                        s_d.target   = op_target(khz, PROG_TIME_US);
                    end
                end
            end
            ST_PROG: begin
                if (s_q.rd_phase) begin
                    // merge with old byte: a cell can only go from 1 to 0
                    s_d.a_wdata  = s_q.a_wdata & arr_rdata;
                    s_d.rd_phase = 1'b0;
                    s_d.a_prog   = 1'b1;
                end else if (timer_done) begin
                    s_d.a_prog = 1'b0;
                    s_d.hold   = 1'b0;
                    s_d.st     = ST_UNLOCKED;
                end else begin
                    s_d.acc = s_q.acc + TICK_STEP;
                end
            end
            ST_PERASE, ST_MERASE: begin
                // erase timing is latched at start; khz writes now only
                // affect the next operation
                if (timer_done) begin
                    s_d.a_perase = 1'b0;
                    s_d.a_merase = 1'b0;
                    s_d.hold     = 1'b0;
                    s_d.st       = ST_LOCKED;
                end else begin
                    s_d.acc = s_q.acc + TICK_STEP;
                end
            end
            default: begin
                s_d.st = ST_LOCKED;
            end
        endcase
        if (hsel && htrans[1] && hready) begin
            if (hwrite) begin
                s_d.wr_pend = 1'b1;
                s_d.wr_idx  = haddr[IDX_LSB+11:IDX_LSB];
                s_d.wr_dbg  = dbg_access;
            end else begin
                s_d.rdata = reg_read(haddr[IDX_LSB+11:IDX_LSB], s_d);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q       <= '0;
            s_q.st    <= ST_LOCKED;
            s_q.ready <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign hrdata          = s_q.rdata;
    assign hreadyout       = s_q.ready;
    assign hresp           = 1'b0;
    assign arr_addr        = s_q.a_addr;
    assign arr_wdata       = s_q.a_wdata;
    assign arr_prog        = s_q.a_prog;
    assign arr_page_erase  = s_q.a_perase;
    assign arr_mass_erase  = s_q.a_merase;
    assign cpu_hold        = s_q.hold;
    assign dbg_read_denied = s_q.rd_deny;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_unlock_pair: assert property (
        s_q.st == ST_FIRST && cmd_wr && wbyte == CMD_UNLOCK2
        |=> s_q.st == ST_UNLOCKED)
        else $error("unlock pair did not unlock");

    a_bad_cmd_relock: assert property (
        s_q.st == ST_UNLOCKED && cmd_wr && wbyte != CMD_PAGE_ERASE
        && wbyte != CMD_MASS_ERASE |=> s_q.st == ST_LOCKED)
        else $error("stray command left controller unlocked");

    a_page_erase_go: assert property (
        s_q.st == ST_UNLOCKED && cmd_wr && wbyte == CMD_PAGE_ERASE
        && global_write_enable
        |=> arr_page_erase && cpu_hold
            && arr_addr[ADDR_W-1:PAGE_LSB] == $past(s_q.page))
        else $error("page erase did not start on selected page");

    a_erase_relock: assert property (
        $fell(arr_page_erase) |-> s_q.st == ST_LOCKED && !cpu_hold)
        else $error("page erase end did not relock or release core");

    a_mass_guard: assert property (
        $rose(arr_mass_erase) |-> $past(global_write_enable)
                                 || $past(s_q.wr_dbg))
        else $error("mass erase started without permission");

    a_prog_clears: assert property (
        $rose(arr_prog) |-> (arr_wdata & ~$past(arr_rdata)) == 8'h00)
        else $error("program would set a bit");

    a_prog_protect: assert property (
        $rose(s_q.st == ST_PROG) |-> addr_writable(arr_addr,
            $past(global_write_enable), $past(top_sector_write_enable)))
        else $error("protected address programmed");

    a_hold_busy: assert property (
        arr_prog || arr_page_erase || arr_mass_erase |-> cpu_hold)
        else $error("core not held during flash operation");

    a_locked_quiet: assert property (
        s_q.st == ST_LOCKED |-> !arr_prog ##1 !arr_prog)
        else $error("locked controller programmed");

    a_first_unlock: assert property (
        s_q.st == ST_LOCKED && cmd_wr && wbyte == CMD_UNLOCK1 |=> s_q.st == ST_FIRST)
        else $error("first unlock byte not recognised");

    a_first_break: assert property (
        s_q.st == ST_FIRST && cmd_wr && wbyte != CMD_UNLOCK2 |=> s_q.st == ST_LOCKED)
        else $error("broken unlock pair did not relock");

    a_page_aligned: assert property (
        $rose(arr_page_erase) |-> arr_addr[PAGE_LSB-1:0] == '0)
        else $error("page erase address not page aligned");

    a_top_sector_only: assert property (
        $rose(arr_page_erase) |-> $past(global_write_enable)
            || ($past(top_sector_write_enable) && arr_addr >= TOP_BASE))
        else $error("page erase outside writable area");

    a_prog_start: assert property (
        $rose(s_q.st == ST_PROG) |-> $past(s_q.st) == ST_UNLOCKED && cpu_hold
            && arr_addr == $past(pm_wr_addr))
        else $error("program did not start at store address");

    a_prog_release: assert property (
        $fell(arr_prog) |-> !cpu_hold && s_q.st == ST_UNLOCKED)
        else $error("program end did not release core");

    a_erase_runs_on: assert property (
        (s_q.st == ST_PERASE || s_q.st == ST_MERASE) && !timer_done
        |=> s_q.st == $past(s_q.st))
        else $error("erase cut short");

    a_merase_alone: assert property (
        $rose(arr_mass_erase) |-> cpu_hold && !arr_page_erase && !arr_prog)
        else $error("mass erase overlapped another operation");

    a_merase_relock: assert property (
        $fell(arr_mass_erase) |-> s_q.st == ST_LOCKED && !cpu_hold)
        else $error("mass erase end did not relock or release core");

    a_page_sel_write: assert property (
        s_q.wr_pend && s_q.wr_idx == IDX_PAGE_SEL
        |=> s_q.page == $past(hwdata[PAGE_SEL_W-1:0]))
        else $error("page select write lost");

    a_khz_high_write: assert property (
        s_q.wr_pend && s_q.wr_idx == IDX_KHZ_HIGH |=> s_q.khz_hi == $past(hwdata[7:0]))
        else $error("clock high byte write lost");

    a_khz_low_write: assert property (
        s_q.wr_pend && s_q.wr_idx == IDX_KHZ_LOW |=> s_q.khz_lo == $past(hwdata[7:0]))
        else $error("clock low byte write lost");

    a_read_deny: assert property (
        $past(hresetn) |-> dbg_read_denied == $past(code_read_protect))
        else $error("read protect not reflected");

    c_prog_done: cover property ($fell(arr_prog));
    c_page_erase: cover property ($fell(arr_page_erase));
    c_mass_erase: cover property ($fell(arr_mass_erase));
    c_unlocked: cover property ($rose(s_q.st == ST_UNLOCKED));
    c_dbg_merase: cover property ($rose(arr_mass_erase) && !global_write_enable);
endmodule

// file: test/flash_array_model.sv
`timescale 1ns/1ns
module flash_array_model (
    input  wire logic        hclk,
    input  wire logic [15:0] arr_addr,
    input  wire logic [7:0]  arr_wdata,
    input  wire logic        arr_prog,
    input  wire logic        arr_page_erase,
    input  wire logic        arr_mass_erase,
    output logic      [7:0]  arr_rdata
);
    logic [7:0] mem [0:65535];
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'hFF;
        end
    end
    assign arr_rdata = mem[arr_addr];
    // bytes stored as given, so a design that skips the merge with old data shows up
    always @(posedge hclk) begin
        if (arr_prog) begin
            mem[arr_addr] <= arr_wdata;
        end
        if (arr_page_erase) begin
            for (int i = 0; i < 512; i++) begin
                mem[{arr_addr[15:9], 9'(i)}] <= 8'hFF;
            end
        end
        if (arr_mass_erase) begin
            for (int i = 0; i < 65536; i++) begin
                mem[i] <= 8'hFF;
            end
        end
    end
endmodule

// file: test/flash_program_erase_controller_tb.sv
`timescale 1ns/1ns
module flash_program_erase_controller_tb;
    import flash_ctrl_pkg::*;
    localparam logic [31:0] A_CMD = {18'h0, IDX_CMD_STAT, 2'b00};
    localparam logic [31:0] A_PS  = {18'h0, IDX_PAGE_SEL, 2'b00};
    localparam logic [31:0] A_KH  = {18'h0, IDX_KHZ_HIGH, 2'b00};
    localparam logic [31:0] A_KL  = {18'h0, IDX_KHZ_LOW, 2'b00};
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, dbg_access, pm_wr_valid;
    logic        global_write_enable, top_sector_write_enable, code_read_protect;
    logic        arr_prog, arr_page_erase, arr_mass_erase, cpu_hold, dbg_read_denied, s;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [15:0] pm_wr_addr, arr_addr;
    logic [7:0]  pm_wr_data, arr_rdata, arr_wdata;
    int          n_errors = 0;
    int          total_checks = 0;
    int          n;

    flash_program_erase_controller #(.PERASE_TIME_US(1000), .MERASE_TIME_US(1000)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .dbg_access(dbg_access),
        .pm_wr_valid(pm_wr_valid), .pm_wr_addr(pm_wr_addr), .pm_wr_data(pm_wr_data),
        .global_write_enable(global_write_enable),
        .top_sector_write_enable(top_sector_write_enable),
        .code_read_protect(code_read_protect), .arr_rdata(arr_rdata), .arr_addr(arr_addr),
        .arr_wdata(arr_wdata), .arr_prog(arr_prog), .arr_page_erase(arr_page_erase),
        .arr_mass_erase(arr_mass_erase), .cpu_hold(cpu_hold),
        .dbg_read_denied(dbg_read_denied));
    flash_array_model u_arr (.hclk(hclk), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
        .arr_prog(arr_prog), .arr_page_erase(arr_page_erase),
        .arr_mass_erase(arr_mass_erase), .arr_rdata(arr_rdata));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    function automatic logic [31:0] mv(input logic [15:0] a);
        return {24'h0, u_arr.mem[a]};
    endfunction

    // the bus answers with zero wait states, but the master still waits for hready
    task automatic wait_rdy;
        int i;
        i = 0;
        do begin
            @(posedge hclk);
            i++;
        end while (hreadyout !== 1'b1 && i < 100);
        if (hreadyout !== 1'b1) begin
            chk("hready_wait", {31'h0, hreadyout}, 32'h1);
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, {24'h0, d}, x);
    endtask

    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(nm, x, e);
    endtask

    // cnt: cycles with an erase strobe high; held: core was stalled at some point
    task automatic wait_idle(output logic held, output int cnt);
        int i;
        held = 1'b0;
        cnt = 0;
        for (i = 0; i < 2000; i++) begin
            @(posedge hclk);
            held = held | cpu_hold;
            cnt += int'(arr_page_erase === 1'b1 || arr_mass_erase === 1'b1);
            if (!(cpu_hold | arr_prog | arr_page_erase | arr_mass_erase)) break;
        end
        if (i == 2000) begin
            chk("idle_wait", {31'h0, cpu_hold}, 32'h0);
        end
    endtask

    task automatic store(input logic [15:0] a, input logic [7:0] d, output logic held);
        int c;
        @(posedge hclk);
        pm_wr_valid <= 1'b1;
        pm_wr_addr <= a;
        pm_wr_data <= d;
        @(posedge hclk);
        pm_wr_valid <= 1'b0;
        wait_idle(held, c);
    endtask

    task automatic unlock;
        wr(A_CMD, CMD_UNLOCK1);
        wr(A_CMD, CMD_UNLOCK2);
    endtask

    // debugger side: read status until the controller reports locked again
    task automatic poll_done;
        logic [31:0] x;
        int i;
        i = 0;
        do begin
            bus(1'b0, A_CMD, 32'h0, x);
            i++;
        end while (x[5:0] != STAT_LOCKED && i < 200);
        chk("poll_done", x, 32'h0);
    endtask

    initial begin
        repeat (20000) @(posedge hclk);
        chk("run_time", 32'h1, 32'h0);
        end_sim();
    end

    initial begin
        {hsel, hwrite, dbg_access, pm_wr_valid, code_read_protect} = '0;
        {global_write_enable, top_sector_write_enable} = 2'h2;
        {haddr, hwdata, htrans, pm_wr_addr, pm_wr_data} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("stat_reset", A_CMD, 32'h0);
        chk("read_allowed", {31'h0, dbg_read_denied}, 32'h0);
        rdc("khz_reset", A_KL, 32'h0);
        rdc("unmapped", 32'h0100, 32'h0);
        wr(A_KH, 8'h00);
        wr(A_KL, 8'h14);
        rdc("khz_low", A_KL, 32'h14);
        store(16'h0204, 8'hA5, s);
        chk("locked_store", mv(16'h0204), 32'hFF);
        wr(A_CMD, CMD_UNLOCK1);
        rdc("stat_first", A_CMD, {26'h0, STAT_FIRST});
        wr(A_CMD, CMD_UNLOCK2);
        rdc("stat_unlocked", A_CMD, {26'h0, STAT_UNLOCKED});
        store(16'h0204, 8'hA5, s);
        chk("prog_first", mv(16'h0204), 32'hA5);
        chk("core_held", {31'h0, s}, 32'h1);
        store(16'h0204, 8'h5A, s);
        chk("prog_clears", mv(16'h0204), 32'h00);
        store(16'h03FF, 8'h00, s);
        store(16'h0400, 8'h12, s);
        rdc("stat_after_prog", A_CMD, {26'h0, STAT_UNLOCKED});
        wr(A_CMD, 8'h11);
        rdc("bad_cmd", A_CMD, 32'h0);
        wr(A_CMD, CMD_UNLOCK2);
        rdc("out_of_order", A_CMD, 32'h0);
        wr(A_CMD, CMD_UNLOCK1);
        wr(A_CMD, 8'h11);
        rdc("broken_pair", A_CMD, 32'h0);
        chk("bad_cmd_okay", {31'h0, hresp}, 32'h0);
        wr(A_PS, 8'h01);
        unlock();
        wr(A_CMD, CMD_PAGE_ERASE);
        wait_idle(s, n);
        chk("perase_cycles", 32'(n), 32'h14);
        chk("perase_hold", {31'h0, s}, 32'h1);
        chk("perase_low", mv(16'h0204), 32'hFF);
        chk("perase_top", mv(16'h03FF), 32'hFF);
        chk("perase_other", mv(16'h0400), 32'h12);
        rdc("perase_relock", A_CMD, 32'h0);
        global_write_enable <= 1'b0;
        top_sector_write_enable <= 1'b1;
        unlock();
        store(16'h0100, 8'h00, s);
        chk("top_only_low", mv(16'h0100), 32'hFF);
        store(16'hFC00, 8'h3C, s);
        chk("top_only_top", mv(16'hFC00), 32'h3C);
        wr(A_CMD, CMD_MASS_ERASE);
        wait_idle(s, n);
        chk("user_merase_refused", mv(16'hFC00), 32'h3C);
        rdc("refused_relock", A_CMD, 32'h0);
        top_sector_write_enable <= 1'b0;
        unlock();
        store(16'hFC01, 8'h00, s);
        chk("all_protected", mv(16'hFC01), 32'hFF);
        dbg_access <= 1'b1;
        wr(A_CMD, CMD_MASS_ERASE);
        dbg_access <= 1'b0;
        rdc("stat_merase", A_CMD, {26'h0, STAT_MERASE});
        poll_done();
        wait_idle(s, n);
        chk("merase_top", mv(16'hFC00), 32'hFF);
        chk("merase_low", mv(16'h0400), 32'hFF);
        rdc("merase_relock", A_CMD, 32'h0);
        code_read_protect <= 1'b1;
        repeat (2) @(posedge hclk);
        chk("read_denied", {31'h0, dbg_read_denied}, 32'h1);
        unlock();
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rdc("reset_relock", A_CMD, 32'h0);
        rdc("reset_page", A_PS, 32'h0);
        end_sim();
    end
endmodule
